//--- cgpm_pkg.sv
// constants for the clock generator and power manager control block
package cgpm_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_OSC = 8'h00;
    localparam logic [7:0] OFF_TALLY = 8'h04;
    localparam logic [7:0] OFF_PLLA = 8'h08;
    localparam logic [7:0] OFF_PLLB = 8'h0c;
    localparam logic [7:0] OFF_MCK = 8'h10;
    localparam logic [7:0] OFF_SCDIS = 8'h14;
    localparam logic [7:0] OFF_SCSTAT = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1c;
    localparam logic [7:0] OFF_MASK = 8'h20;
    // osc control fields
    localparam int OSC_ON_BIT = 0;
    localparam int EXT_FEED_BIT = 1;
    localparam int OSC_CNT_LSB = 8;
    localparam int OSC_CNT_W = 8;
    // pll config fields
    localparam int RATIO_LSB = 0;
    localparam int RATIO_W = 8;
    localparam int SETTLE_LSB = 8;
    localparam int SETTLE_W = 6;
    localparam int FACTOR_LSB = 16;
    localparam int FACTOR_W = 11;
    // master clock fields
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 2;
    localparam int HALV_LSB = 2;
    localparam int HALV_W = 3;
    localparam logic [2:0] HALV_MAX = 3'h6;
    // status bits
    localparam int ST_SETTLED = 0;
    localparam int ST_PLL_A_LOCKED = 1;
    localparam int ST_PLL_B_LOCKED = 2;
    localparam int ST_MCK = 3;
    localparam int ST_W = 4;
    localparam int TALLY_W = 16;
    localparam int TALLY_DONE_BIT = 16;
    localparam int CPU_BIT = 0;
    // timing in slow clock periods
    localparam logic [2:0] SLOW_PER_TICK = 3'h7;
    localparam logic [4:0] TALLY_PERIODS = 5'h10;
    localparam logic [1:0] MCK_SWITCH_SLOW = 2'h2;
    localparam int NPLL = 2;
    typedef enum logic [3:0] {
        TALLY_IDLE = 4'b0001,
        TALLY_ARM = 4'b0010,
        TALLY_RUN = 4'b0100,
        TALLY_DONE = 4'b1000
    } cgpm_tally_e;
endpackage

//--- cgpm_ctrl.sv
// clock generator and power manager control, apb register slave
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R01: after reset the crystal oscillator is off and slow clock drives the system
// R02: clearing crystal_osc_on clears crystal_settled at once
// R03: writing osc on with count clears settled, loads counter ticking every 8 slow periods
// R04: crystal_settle_count is eight bits wide, about 62 ms at most
// R05: counter at zero sets crystal_settled; masked event requests interrupt
// R06: software picks a settle count covering the crystal start-up
// R07: tally starts counting main clock at next slow rising edge after settled
// R08: sixteenth slow falling edge stops tally and sets crystal_tally_done
// R09: external clock feed needs external_clock_feed one and osc on zero
// R10: each pll input divider takes ratios 1 to 255
// R11: ratio zero holds divider and pll output low; ratios reset to zero
// R12: pll output is source times factor plus one over ratio
// R13: factor zero disables pll, nonzero enables it
// R14: re-enable or parameter change clears lock and loads settle cycles
// R15: lock counter counts down per slow cycle; zero sets lock flag
// R16: software sets settle cycles to cover pll settling
// R17: pll b is best run at 12 MHz input and 96 MHz output
// R18: master clock source picked then divided by power of two 1 to 64
// R19: master clock config write clears settled until new clock runs
// R20: cpu clock stops on disable write; state readable in status register
// R21: cpu clock on after reset and woken by any enabled interrupt
// R22: current instruction completes before stop; other masters keep bus
// R23: software always writes one into bit 29 of pll a config
// R24: masked settled, lock and master clock events form one interrupt line
module cgpm_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cgpm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slowClkPin,
    input wire logic mainClkPin,
    input wire logic cpuIrqPending,
    input wire logic instrDone,
    output logic crystalOscOn,
    output logic externalClockFeed,
    output logic [7:0] pllARatio,
    output logic [10:0] pllAFactor,
    output logic pllAEnable,
    output logic pllAHoldLow,
    output logic [7:0] pllBRatio,
    output logic [10:0] pllBFactor,
    output logic pllBEnable,
    output logic pllBHoldLow,
    output logic [1:0] clockSourcePick,
    output logic [2:0] clockHalvingSteps,
    output logic cpuClockGate,
    output logic irqReq
);
    // pin synchronisers
    logic slowS1_r, slowS2_r, slowPrev_r;
    logic mainS1_r, mainS2_r, mainPrev_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slowS1_r <= 1'b0;
            slowS2_r <= 1'b0;
            slowPrev_r <= 1'b0;
            mainS1_r <= 1'b0;
            mainS2_r <= 1'b0;
            mainPrev_r <= 1'b0;
        end else begin
            slowS1_r <= slowClkPin;
            slowS2_r <= slowS1_r;
            slowPrev_r <= slowS2_r;
            mainS1_r <= mainClkPin;
            mainS2_r <= mainS1_r;
            mainPrev_r <= mainS2_r;
        end
    end

    wire slowRise = slowS2_r & ~slowPrev_r;
    wire slowFall = ~slowS2_r & slowPrev_r;
    wire mainRise = mainS2_r & ~mainPrev_r;

    // apb decode
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    wire setupPh = psel & ~penable;
    wire wrStb = psel & penable & pready_r & pwrite;
    wire selOsc = (paddr == cgpm_pkg::OFF_OSC);
    wire selTally = (paddr == cgpm_pkg::OFF_TALLY);
    wire selPllA = (paddr == cgpm_pkg::OFF_PLLA);
    wire selPllB = (paddr == cgpm_pkg::OFF_PLLB);
    wire selMck = (paddr == cgpm_pkg::OFF_MCK);
    wire selScDis = (paddr == cgpm_pkg::OFF_SCDIS);
    wire selScStat = (paddr == cgpm_pkg::OFF_SCSTAT);
    wire selStat = (paddr == cgpm_pkg::OFF_STAT);
    wire selMask = (paddr == cgpm_pkg::OFF_MASK);
    wire mapped = selOsc | selTally | selPllA | selPllB | selMck | selScDis
        | selScStat | selStat | selMask;
    wire wrOsc = wrStb & selOsc;
    wire wrMck = wrStb & selMck;
    wire wrScDis = wrStb & selScDis;
    wire wrMask = wrStb & selMask;
    wire [1:0] wrPll = {wrStb & selPllB, wrStb & selPllA};

    // oscillator control and settle counter
    logic oscOn_r;
    logic extFeed_r;
    logic [cgpm_pkg::OSC_CNT_W-1:0] oscCnt_r;
    logic [cgpm_pkg::OSC_CNT_W-1:0] settleCnt_r;
    logic [2:0] slowDiv_r;
    logic settling_r;
    logic settled_r;
    wire newOscOn = pwdata[cgpm_pkg::OSC_ON_BIT];
    wire [cgpm_pkg::OSC_CNT_W-1:0] newOscCnt =
        pwdata[cgpm_pkg::OSC_CNT_LSB +: cgpm_pkg::OSC_CNT_W];
    wire divTick = slowRise & (slowDiv_r == cgpm_pkg::SLOW_PER_TICK);
    wire settleHit = settling_r & (settleCnt_r == '0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oscOn_r <= 1'b0; // R01
            extFeed_r <= 1'b0;
            oscCnt_r <= '0;
        end else if (wrOsc) begin
            oscOn_r <= newOscOn;
            extFeed_r <= pwdata[cgpm_pkg::EXT_FEED_BIT];
            oscCnt_r <= newOscCnt; // R04
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slowDiv_r <= '0;
        end else if (wrOsc) begin
            slowDiv_r <= '0;
        end else if (slowRise) begin
            slowDiv_r <= slowDiv_r + 3'h1; // R03
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settleCnt_r <= '0;
            settling_r <= 1'b0;
            settled_r <= 1'b0;
        end else if (wrOsc) begin
            settleCnt_r <= newOscCnt; // R03
            settling_r <= newOscOn;
            settled_r <= 1'b0; // R02 R03
        end else if (settleHit) begin
            settling_r <= 1'b0;
            settled_r <= 1'b1; // R05
        end else if (settling_r && divTick) begin
            settleCnt_r <= settleCnt_r - 8'h01; // R03
        end
    end

    // main clock frequency tally
    cgpm_pkg::cgpm_tally_e tally_r, tally_nxt;
    logic [cgpm_pkg::TALLY_W-1:0] tallyCnt_r;
    logic [4:0] fallCnt_r;
    logic tallyDone_r;
    wire lastFall = slowFall & (fallCnt_r == cgpm_pkg::TALLY_PERIODS - 5'h01);

    always_comb begin
        tally_nxt = tally_r;
        case (tally_r)
            cgpm_pkg::TALLY_IDLE: begin
                if (settled_r) begin
                    tally_nxt = cgpm_pkg::TALLY_ARM;
                end
            end
            cgpm_pkg::TALLY_ARM: begin
                if (slowRise) begin
                    tally_nxt = cgpm_pkg::TALLY_RUN; // R07
                end
            end
            cgpm_pkg::TALLY_RUN: begin
                if (lastFall) begin
                    tally_nxt = cgpm_pkg::TALLY_DONE; // R08
                end
            end
            cgpm_pkg::TALLY_DONE: tally_nxt = cgpm_pkg::TALLY_DONE;
            default: tally_nxt = cgpm_pkg::TALLY_IDLE;
        endcase
        if (!settled_r) begin
            tally_nxt = cgpm_pkg::TALLY_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tally_r <= cgpm_pkg::TALLY_IDLE;
        end else begin
            tally_r <= tally_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tallyCnt_r <= '0;
            fallCnt_r <= '0;
            tallyDone_r <= 1'b0;
        end else if (tally_r == cgpm_pkg::TALLY_IDLE) begin
            tallyCnt_r <= '0;
            fallCnt_r <= '0;
            tallyDone_r <= 1'b0;
        end else if (tally_r == cgpm_pkg::TALLY_RUN) begin
            if (mainRise) begin
                tallyCnt_r <= tallyCnt_r + 16'h0001; // R07
            end
            if (slowFall) begin
                fallCnt_r <= fallCnt_r + 5'h01;
            end
            if (lastFall) begin
                tallyDone_r <= 1'b1; // R08
            end
        end
    end

    // pll configuration and lock counters
    logic [cgpm_pkg::RATIO_W-1:0] ratio_r [cgpm_pkg::NPLL];
    logic [cgpm_pkg::FACTOR_W-1:0] factor_r [cgpm_pkg::NPLL];
    logic [cgpm_pkg::SETTLE_W-1:0] pllSettle_r [cgpm_pkg::NPLL];
    logic [cgpm_pkg::SETTLE_W-1:0] lockCnt_r [cgpm_pkg::NPLL];
    logic [cgpm_pkg::NPLL-1:0] locking_r;
    logic [cgpm_pkg::NPLL-1:0] locked_r;
    wire [cgpm_pkg::RATIO_W-1:0] newRatio = pwdata[cgpm_pkg::RATIO_LSB +: cgpm_pkg::RATIO_W];
    wire [cgpm_pkg::FACTOR_W-1:0] newFactor =
        pwdata[cgpm_pkg::FACTOR_LSB +: cgpm_pkg::FACTOR_W];
    wire [cgpm_pkg::SETTLE_W-1:0] newSettle =
        pwdata[cgpm_pkg::SETTLE_LSB +: cgpm_pkg::SETTLE_W];

    for (genvar i = 0; i < cgpm_pkg::NPLL; i++) begin : g_pll
        wire changed = (newRatio != ratio_r[i]) | (newFactor != factor_r[i])
            | (newSettle != pllSettle_r[i]);
        wire restart = wrPll[i] & changed & (newFactor != '0);
        wire off = factor_r[i] == '0;

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                ratio_r[i] <= '0; // R11
                factor_r[i] <= '0;
                pllSettle_r[i] <= '0;
            end else if (wrPll[i]) begin
                ratio_r[i] <= newRatio; // R10 R12
                factor_r[i] <= newFactor; // R13
                pllSettle_r[i] <= newSettle;
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                lockCnt_r[i] <= '0;
                locking_r[i] <= 1'b0;
                locked_r[i] <= 1'b0;
            end else if (restart) begin
                lockCnt_r[i] <= newSettle; // R14
                locking_r[i] <= 1'b1;
                locked_r[i] <= 1'b0; // R14
            end else if (wrPll[i] && newFactor == '0) begin
                locking_r[i] <= 1'b0; // R13
                locked_r[i] <= 1'b0;
            end else if (locking_r[i] && !off && lockCnt_r[i] == '0) begin
                locking_r[i] <= 1'b0;
                locked_r[i] <= 1'b1; // R15
            end else if (locking_r[i] && slowRise) begin
                lockCnt_r[i] <= lockCnt_r[i] - 6'h01; // R15
            end
        end
    end

    // master clock selection
    logic [cgpm_pkg::SRC_W-1:0] mckSrc_r;
    logic [cgpm_pkg::HALV_W-1:0] mckHalv_r;
    logic [1:0] mckWait_r;
    logic mckSettled_r;
    wire [cgpm_pkg::HALV_W-1:0] newHalv = pwdata[cgpm_pkg::HALV_LSB +: cgpm_pkg::HALV_W];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mckSrc_r <= '0; // R01
            mckHalv_r <= '0;
        end else if (wrMck) begin
            mckSrc_r <= pwdata[cgpm_pkg::SRC_LSB +: cgpm_pkg::SRC_W]; // R18
            mckHalv_r <= (newHalv > cgpm_pkg::HALV_MAX) ? cgpm_pkg::HALV_MAX : newHalv; // R18
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mckWait_r <= '0;
            mckSettled_r <= 1'b1;
        end else if (wrMck) begin
            mckWait_r <= cgpm_pkg::MCK_SWITCH_SLOW;
            mckSettled_r <= 1'b0; // R19
        end else if (!mckSettled_r && mckWait_r == '0) begin
            mckSettled_r <= 1'b1; // R19
        end else if (slowRise && mckWait_r != '0) begin
            mckWait_r <= mckWait_r - 2'h1;
        end
    end

    // processor clock gate
    logic cpuOn_r;
    logic stopReq_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpuOn_r <= 1'b1; // R21
            stopReq_r <= 1'b0;
        end else if (cpuIrqPending) begin
            cpuOn_r <= 1'b1; // R21
            stopReq_r <= 1'b0;
        end else if (wrScDis && pwdata[cgpm_pkg::CPU_BIT]) begin
            stopReq_r <= cpuOn_r; // R20
        end else if (stopReq_r && instrDone) begin
            cpuOn_r <= 1'b0; // R22
            stopReq_r <= 1'b0;
        end
    end

    // status, mask and interrupt
    logic [cgpm_pkg::ST_W-1:0] mask_r;
    logic irq_r;
    wire [cgpm_pkg::ST_W-1:0] status = {mckSettled_r, locked_r[1], locked_r[0], settled_r};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wrMask) begin
                mask_r <= pwdata[cgpm_pkg::ST_W-1:0];
            end
            irq_r <= |(status & mask_r); // R05 R15 R19 R24
        end
    end

    // read mux
    wire [31:0] rdOsc = {16'h0000, oscCnt_r, 6'h00, extFeed_r, oscOn_r};
    wire [31:0] rdTally = {15'h0000, tallyDone_r, tallyCnt_r}; // R08
    wire [31:0] rdPllA = {5'h00, factor_r[0], 2'h0, pllSettle_r[0], ratio_r[0]};
    wire [31:0] rdPllB = {5'h00, factor_r[1], 2'h0, pllSettle_r[1], ratio_r[1]};
    wire [31:0] rdMck = {27'h0000000, mckHalv_r, mckSrc_r};
    wire [31:0] rdCpu = {31'h00000000, cpuOn_r}; // R20
    wire [31:0] rdStat = {28'h0000000, status};
    wire [31:0] rdMask = {28'h0000000, mask_r};
    wire [31:0] rdMux = selOsc ? rdOsc
        : selTally ? rdTally
        : selPllA ? rdPllA
        : selPllB ? rdPllB
        : selMck ? rdMck
        : selScStat ? rdCpu
        : selStat ? rdStat
        : selMask ? rdMask
        : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setupPh;
            pslverr_r <= setupPh & ~mapped;
            if (setupPh && !pwrite) begin
                prdata_r <= rdMux;
            end
        end
    end

    // registered outputs to the analog cells
    logic [7:0] ratioOutA_r, ratioOutB_r;
    logic [10:0] factorOutA_r, factorOutB_r;
    logic [1:0] pllOn_r, pllHold_r;
    logic [1:0] srcOut_r;
    logic [2:0] halvOut_r;
    logic oscOut_r, feedOut_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ratioOutA_r <= '0;
            ratioOutB_r <= '0;
            factorOutA_r <= '0;
            factorOutB_r <= '0;
            pllOn_r <= '0;
            pllHold_r <= 2'h3;
            srcOut_r <= '0;
            halvOut_r <= '0;
            oscOut_r <= 1'b0;
            feedOut_r <= 1'b0;
        end else begin
            ratioOutA_r <= ratio_r[0];
            ratioOutB_r <= ratio_r[1];
            factorOutA_r <= factor_r[0];
            factorOutB_r <= factor_r[1];
            pllOn_r <= {factor_r[1] != '0, factor_r[0] != '0}; // R13
            pllHold_r <= {ratio_r[1] == '0, ratio_r[0] == '0}; // R11
            srcOut_r <= mckSrc_r;
            halvOut_r <= mckHalv_r;
            oscOut_r <= oscOn_r;
            feedOut_r <= extFeed_r;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign crystalOscOn = oscOut_r;
    assign externalClockFeed = feedOut_r;
    assign pllARatio = ratioOutA_r;
    assign pllAFactor = factorOutA_r;
    assign pllAEnable = pllOn_r[0];
    assign pllAHoldLow = pllHold_r[0];
    assign pllBRatio = ratioOutB_r;
    assign pllBFactor = factorOutB_r;
    assign pllBEnable = pllOn_r[1];
    assign pllBHoldLow = pllHold_r[1];
    assign clockSourcePick = srcOut_r;
    assign clockHalvingSteps = halvOut_r;
    assign cpuClockGate = cpuOn_r;
    assign irqReq = irq_r;
endmodule

//--- cgpm_ctrl_monitor.sv
// concurrent checks on the ports of the clock and power control block
`timescale 1ns/1ps
module cgpm_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cgpm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpuIrqPending,
    input wire logic instrDone,
    input wire logic crystalOscOn,
    input wire logic [7:0] pllARatio,
    input wire logic [10:0] pllAFactor,
    input wire logic pllAEnable,
    input wire logic pllAHoldLow,
    input wire logic [7:0] pllBRatio,
    input wire logic [10:0] pllBFactor,
    input wire logic pllBEnable,
    input wire logic pllBHoldLow,
    input wire logic [2:0] clockHalvingSteps,
    input wire logic cpuClockGate
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(logic [7:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    chk_reset_quiet: assert property (!$past(rst_n) |-> !crystalOscOn && cpuClockGate)
        else $error("outputs wrong after reset");
    chk_ready_next: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_osc_follow: assert property (s_wr(cgpm_pkg::OFF_OSC) |-> ##2 crystalOscOn == $past(pwdata[0], 2))
        else $error("oscillator enable not written");
    chk_ratio_follow: assert property (s_wr(cgpm_pkg::OFF_PLLA) |-> ##2 pllARatio == $past(pwdata[7:0], 2))
        else $error("divider ratio not written");
    chk_hold_zero: assert property ((pllAHoldLow == (pllARatio == 8'h00)) && (pllBHoldLow == (pllBRatio == 8'h00)))
        else $error("hold low not tied to zero ratio");
    chk_pll_enable: assert property ((pllAEnable == (pllAFactor != 11'h000)) && (pllBEnable == (pllBFactor != 11'h000)))
        else $error("pll enable not tied to factor");
    chk_halving_max: assert property (clockHalvingSteps <= cgpm_pkg::HALV_MAX)
        else $error("prescaler beyond divide by 64");
    chk_gate_stop: assert property ($fell(cpuClockGate) |-> $past(instrDone))
        else $error("cpu clock stopped mid instruction");
    chk_irq_wake: assert property (cpuIrqPending |-> ##[0:2] cpuClockGate)
        else $error("cpu clock not woken");
endmodule

//--- cgpm_osc_model.sv
// behavioural slow crystal and main oscillator pins
`timescale 1ns/1ps
module cgpm_osc_model #(
    parameter int SLOW_HALF = 813,
    parameter int MAIN_HALF = 201
) (
    input wire logic oscOn,
    input wire logic extFeed,
    output logic slowClk,
    output logic mainClk
);
    initial slowClk = 1'b0;
    initial mainClk = 1'b0;
    // slow clock is permanent
    always #(SLOW_HALF) slowClk = ~slowClk;
    // main pin still while oscillator off and no external feed
    always #(MAIN_HALF) mainClk = (oscOn || extFeed) ? ~mainClk : 1'b0;
endmodule

//--- cgpm_ctrl_tb.sv
// self-checking bench for the clock and power control block
`timescale 1ns/1ps
module cgpm_ctrl_tb;
    localparam int SLOW_HALF = 813;
    localparam int MAIN_HALF = 201;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpuIrqPending = 1'b0, instrDone = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [7:0] pa;
    logic [31:0] pwdata = 32'h0, prdata, rd, wd;
    logic pready, pslverr, er, slowClkPin, mainClkPin, crystalOscOn, externalClockFeed;
    logic pllAEnable, pllAHoldLow, pllBEnable, pllBHoldLow, cpuClockGate, irqReq;
    logic [7:0] pllARatio, pllBRatio;
    logic [10:0] pllAFactor, pllBFactor;
    logic [1:0] clockSourcePick;
    logic [2:0] clockHalvingSteps;
    int error_cnt = 0, samples_checked = 0, cycles = 0, t0, n, e, ratio, factor, settle;
    cgpm_ctrl cgpm_ctrl_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .slowClkPin, .mainClkPin, .cpuIrqPending, .instrDone,
        .crystalOscOn, .externalClockFeed, .pllARatio, .pllAFactor, .pllAEnable, .pllAHoldLow,
        .pllBRatio, .pllBFactor, .pllBEnable, .pllBHoldLow, .clockSourcePick,
        .clockHalvingSteps, .cpuClockGate, .irqReq);
    cgpm_osc_model #(.SLOW_HALF(SLOW_HALF), .MAIN_HALF(MAIN_HALF)) cgpm_osc_model_inst (
        .oscOn(crystalOscOn), .extFeed(externalClockFeed), .slowClk(slowClkPin),
        .mainClk(mainClkPin));
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task conclude;
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll a status bit, n gets cycles since t0
    task poll(input logic [7:0] a, input int b, input logic v);
        int k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0);
            k++;
        end while (rd[b] !== v && k < 3000);
        n = cycles - t0;
    endtask
    initial begin
        n = $urandom(62975);
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
        chk(rd, 32'h8);
        chk({cpuClockGate, pllAHoldLow, pllBHoldLow, crystalOscOn}, 4'he);
        apb(1'b0, 8'h24, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, cgpm_pkg::OFF_OSC, 32'h0201);
        t0 = cycles;
        apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
        chk(rd[cgpm_pkg::ST_SETTLED], 1'b0);
        poll(cgpm_pkg::OFF_STAT, cgpm_pkg::ST_SETTLED, 1'b1);
        e = 2 * 8 * 2 * SLOW_HALF / 50;
        chk(32'(n > e - 48 && n < e + 48), 32'h1);
        apb(1'b1, cgpm_pkg::OFF_MASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irqReq, 1'b1);
        poll(cgpm_pkg::OFF_TALLY, cgpm_pkg::TALLY_DONE_BIT, 1'b1);
        e = 16 * SLOW_HALF / MAIN_HALF;
        chk(32'(rd[15:0] > e - 3 && rd[15:0] < e + 3), 32'h1);
        apb(1'b1, cgpm_pkg::OFF_OSC, 32'h0200);
        apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
        chk(rd[cgpm_pkg::ST_SETTLED], 1'b0);
        chk(irqReq, 1'b0);
        apb(1'b1, cgpm_pkg::OFF_OSC, 32'h0002);
        apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
        chk(rd[cgpm_pkg::ST_SETTLED], 1'b0);
        chk({externalClockFeed, crystalOscOn}, 2'b10);
        apb(1'b1, cgpm_pkg::OFF_MASK, 32'h6);
        for (int i = 0; i < 2; i++) begin
            pa = i ? cgpm_pkg::OFF_PLLB : cgpm_pkg::OFF_PLLA;
            ratio = $urandom_range(255, 1);
            factor = $urandom_range(2047, 1);
            settle = $urandom_range(7, 1);
            wd = 32'h2000_0000 | (factor << 16) | (settle << 8) | ratio;
            apb(1'b1, pa, wd);
            t0 = cycles;
            apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
            chk(rd[cgpm_pkg::ST_PLL_A_LOCKED + i], 1'b0);
            chk(i ? {pllBEnable, pllBHoldLow, pllBFactor, pllBRatio}
                : {pllAEnable, pllAHoldLow, pllAFactor, pllARatio},
                {2'b10, 11'(factor), 8'(ratio)});
            poll(cgpm_pkg::OFF_STAT, cgpm_pkg::ST_PLL_A_LOCKED + i, 1'b1);
            e = settle * 2 * SLOW_HALF / 50;
            chk(32'(n > e - 40 && n < e + 40), 32'h1);
            repeat (3) @(posedge clk_sys);
            chk(irqReq, 1'b1);
            apb(1'b1, pa, wd);
            apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
            chk(rd[cgpm_pkg::ST_PLL_A_LOCKED + i], 1'b1);
            apb(1'b1, pa, 32'h2000_0000 | (settle << 8));
            apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
            chk(rd[cgpm_pkg::ST_PLL_A_LOCKED + i], 1'b0);
            chk(i ? {pllBEnable, pllBHoldLow} : {pllAEnable, pllAHoldLow}, 2'b01);
        end
        apb(1'b1, cgpm_pkg::OFF_PLLB, 32'h0007_0101);
        apb(1'b0, cgpm_pkg::OFF_PLLB, 32'h0);
        chk(rd, 32'h0007_0101);
        chk({pllBEnable, pllBHoldLow, pllBFactor, pllBRatio}, {2'b10, 11'h007, 8'h01});
        for (int h = 0; h < 8; h++) begin
            apb(1'b1, cgpm_pkg::OFF_MCK, (h << 2) | (h % 4));
            apb(1'b0, cgpm_pkg::OFF_STAT, 32'h0);
            chk(rd[cgpm_pkg::ST_MCK], 1'b0);
            chk({clockSourcePick, clockHalvingSteps}, {2'(h % 4), 3'(h > 6 ? 6 : h)});
            poll(cgpm_pkg::OFF_STAT, cgpm_pkg::ST_MCK, 1'b1);
            chk(rd[cgpm_pkg::ST_MCK], 1'b1);
        end
        apb(1'b1, cgpm_pkg::OFF_SCDIS, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk(cpuClockGate, 1'b1);
        instrDone <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(cpuClockGate, 1'b0);
        apb(1'b0, cgpm_pkg::OFF_SCSTAT, 32'h0);
        chk(rd[cgpm_pkg::CPU_BIT], 1'b0);
        cpuIrqPending <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(cpuClockGate, 1'b1);
        apb(1'b0, cgpm_pkg::OFF_SCSTAT, 32'h0);
        chk(rd[cgpm_pkg::CPU_BIT], 1'b1);
        conclude();
    end
endmodule
bind cgpm_ctrl cgpm_ctrl_monitor cgpm_ctrl_monitor_inst (.clk_sys, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .cpuIrqPending, .instrDone, .crystalOscOn,
    .pllARatio, .pllAFactor, .pllAEnable, .pllAHoldLow, .pllBRatio, .pllBFactor, .pllBEnable,
    .pllBHoldLow, .clockHalvingSteps, .cpuClockGate);
